/* rtl/cnlc_map.vh */
// Constants for the next-lookup action controller: APB map, fields, codes.
// Assumes inclusion by the controller and by its bench.
`ifndef CNLC_MAP_VH
`define CNLC_MAP_VH
`define CNLC_ADDR_CTRL 12'h000
`define CNLC_ADDR_ACT0 12'h004
`define CNLC_ADDR_ACT1 12'h008
`define CNLC_ADDR_FRAME 12'h00c
`define CNLC_ADDR_RES0 12'h010
`define CNLC_ADDR_RES1 12'h014
`define CNLC_ADDR_PTBL 12'h018
`define CNLC_CTRL_GO 0
`define CNLC_CTRL_REDUCED 1
`define CNLC_CTRL_TRI_SEL 2
`define CNLC_KEY_DEFAULT 4'h0
`define CNLC_KEY_TRI_VID 4'h5
`define CNLC_KEY_NORMAL_DST 4'h8
`define CNLC_KEY_DONE 4'hf
`define CNLC_SKIP_NONE 2'h0
`define CNLC_SKIP_LINK 2'h1
`define CNLC_SKIP_NET_LINK 2'h2
`define CNLC_TYPE_ETH 2'h0
`define CNLC_TYPE_CW 2'h1
`define CNLC_TYPE_DATA 2'h3
`define CNLC_MAC_BYTES 8'h0c
`define CNLC_TAG_BYTES 8'h04
`define CNLC_ETYPE_BYTES 8'h02
`define CNLC_IP6_BYTES 8'h28
`define CNLC_STRIP_MAX 8'h2a
`define CNLC_PT_MAX 5'h10
`define CNLC_PTBL_RESET 24'hfac688
`endif

/* rtl/cnlc_action_ctrl.v */
// Applies next-lookup and frame-pointer fields of one classifier action.
// Assumes an APB master on ref_clk; frame header facts are loaded by software.
//
// How it works
// - Forced point from 5-bit or table field
// - Key format override, zero keeps default
// - Format 15 ends all remaining lookups
// - Format 8 swaps destination into source fields
// - Format 5 passed on unchanged; CTRL selector bit not applied here
// - Quad-byte advance counted in four bytes
// - Dual-byte advance counted in two bytes
// - Skipped labels already moved, not recounted
// - Protocol skip first, then normalized advance
// - Skip zero none; one passes MACs, tags
// - Skip two passes link and IP; three reserved
// - IPv4 skip includes option words
// - Two-bit layer type at new pointer
// - Type replaced if moved or data with key
// - Strip flag removes bytes before pointer
// - Pointer updated before strip evaluated
// - Strip limited to 42 bytes
// - Two-bit staging control with actions
`timescale 1ns/1ps
`include "cnlc_map.vh"
module cnlc_action_ctrl
(
	input wire ref_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg [7:0] frame_ptr,
	output reg [1:0] frame_type,
	output reg [4:0] forced_stage_point,
	output reg [1:0] stage_action,
	output reg [3:0] key_format,
	output reg key_swap_dst,
	output reg lookups_finished,
	output reg [7:0] strip_len,
	output reg strip_req,
	output reg result_valid
);
	// Action word 0: [4:0] point, [7:5] small point, [9:8] stage ctrl,
	// [13:10] key format, [15:14] quad, [20:16] dual, [22:21] skip,
	// [24:23] layer type, [25] strip
	reg [31:0] act0_q;
	// Frame word: [7:0] ptr, [9:8] type, [11:10] tags, [12] ipv4,
	// [13] ipv6, [17:14] ihl
	reg [31:0] frame_q;
	reg [2:0] ctrl_q;
	reg [23:0] ptbl_q;
	reg busy_q;
	reg strip_clip_q;
	reg [7:0] skip_bytes;
	reg [7:0] new_ptr;
	reg [7:0] pt_small;
	wire acc;
	wire wr;
	wire rd_ok;
	wire setup;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign setup = psel & ~penable;

	function [7:0] link_len;
		input [1:0] tags;
		begin
			link_len = `CNLC_MAC_BYTES + `CNLC_ETYPE_BYTES +
				({6'h00, tags} << 2);
		end
	endfunction

	// IPv4 header length from IHL words covers options
	function [7:0] ip_len;
		input v4;
		input [3:0] ihl;
		begin
			ip_len = v4 ? {2'b00, ihl, 2'b00} : `CNLC_IP6_BYTES;
		end
	endfunction

	// Four-byte units of the quad field
	function [7:0] quad_bytes;
		input [1:0] units;
		begin
			quad_bytes = {4'h0, units, 2'b00};
		end
	endfunction

	// Two-byte units of the dual field
	function [7:0] dual_bytes;
		input [4:0] units;
		begin
			dual_bytes = {2'b00, units, 1'b0};
		end
	endfunction

	// Rewriter cannot strip past its limit, so clip here
	function [7:0] strip_amount;
		input ena;
		input [7:0] ptr;
		begin
			if (!ena)
				strip_amount = 8'h00;
			else if (ptr > `CNLC_STRIP_MAX)
				strip_amount = `CNLC_STRIP_MAX;
			else
				strip_amount = ptr;
		end
	endfunction

	// Triple-VID variant is picked by the key generator from CTRL,
	// so the code itself passes unchanged
	function [3:0] next_key;
		input [3:0] code;
		begin
			case (code)
				`CNLC_KEY_TRI_VID: next_key = `CNLC_KEY_TRI_VID;
				default: next_key = code;
			endcase
		end
	endfunction

	// Type follows a moved pointer, or raw data given a key
	function type_moves;
		input [7:0] old_ptr;
		input [7:0] nxt_ptr;
		input [1:0] old_type;
		input [3:0] code;
		begin
			type_moves = (nxt_ptr != old_ptr) ||
				(old_type == `CNLC_TYPE_DATA &&
				code != `CNLC_KEY_DEFAULT);
		end
	endfunction

	// Reduced actions index the eight-entry point table
	function [2:0] small_point;
		input [23:0] tbl;
		input [2:0] idx;
		begin
			small_point = tbl[3*idx +: 3];
		end
	endfunction

	wire [1:0] skip_sel = act0_q[22:21];
	wire is_ip = frame_q[12] | frame_q[13];

	always @*
	begin
		skip_bytes = 8'h00;
		pt_small = {5'h00, small_point(ptbl_q, act0_q[7:5])};
		case (skip_sel)
			`CNLC_SKIP_LINK:
				if (frame_q[9:8] == `CNLC_TYPE_ETH)
					skip_bytes = link_len(frame_q[11:10]);
			`CNLC_SKIP_NET_LINK:
				if (frame_q[9:8] == `CNLC_TYPE_ETH && is_ip)
					skip_bytes = link_len(frame_q[11:10]) +
						ip_len(frame_q[12], frame_q[17:14]);
				else if (frame_q[9:8] == `CNLC_TYPE_CW && is_ip)
					skip_bytes = ip_len(frame_q[12], frame_q[17:14]);
			default:
				skip_bytes = 8'h00; // Reserved code moves nothing
		endcase
		// Skip first, then the normalized units; pointer already past
		// any skipped labels so they are not added again
		new_ptr = frame_q[7:0] + skip_bytes +
			quad_bytes(act0_q[15:14]) +
			dual_bytes(act0_q[20:16]);
	end

	assign rd_ok = (paddr == `CNLC_ADDR_CTRL) || (paddr == `CNLC_ADDR_ACT0) ||
		(paddr == `CNLC_ADDR_FRAME) || (paddr == `CNLC_ADDR_RES0) ||
		(paddr == `CNLC_ADDR_RES1) || (paddr == `CNLC_ADDR_PTBL) ||
		(paddr == `CNLC_ADDR_ACT1);

	always @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			act0_q <= 32'h00000000;
			frame_q <= 32'h00000000;
			ctrl_q <= 3'h0;
			ptbl_q <= `CNLC_PTBL_RESET;
			busy_q <= 1'b0;
			strip_clip_q <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			frame_ptr <= 8'h00;
			frame_type <= 2'h0;
			forced_stage_point <= 5'h00;
			stage_action <= 2'h0;
			key_format <= 4'h0;
			key_swap_dst <= 1'b0;
			lookups_finished <= 1'b0;
			strip_len <= 8'h00;
			strip_req <= 1'b0;
			result_valid <= 1'b0;
		end
		else
		begin
			// Fixed one wait-free access phase keeps the master simple
			pready <= setup;
			pslverr <= setup & ~rd_ok;
			result_valid <= 1'b0;
			busy_q <= 1'b0;
			if (setup & ~pwrite)
			begin
				case (paddr)
					`CNLC_ADDR_CTRL: prdata <= {29'h0, ctrl_q};
					`CNLC_ADDR_ACT0: prdata <= act0_q;
					`CNLC_ADDR_FRAME: prdata <= frame_q;
					`CNLC_ADDR_RES0: prdata <= {4'h0, strip_clip_q,
						lookups_finished, key_swap_dst, key_format,
						stage_action, forced_stage_point, frame_type,
						frame_ptr};
					`CNLC_ADDR_RES1: prdata <= {22'h0, busy_q, strip_req,
						strip_len};
					`CNLC_ADDR_PTBL: prdata <= {8'h00, ptbl_q};
					default: prdata <= 32'h00000000;
				endcase
			end
			if (wr & pready)
			begin
				case (paddr)
					`CNLC_ADDR_CTRL: ctrl_q <= pwdata[2:0];
					`CNLC_ADDR_ACT0: act0_q <= pwdata;
					`CNLC_ADDR_FRAME: frame_q <= pwdata;
					`CNLC_ADDR_PTBL: ptbl_q <= pwdata[23:0];
					default: ;
				endcase
				busy_q <= (paddr == `CNLC_ADDR_CTRL) & pwdata[`CNLC_CTRL_GO];
			end
			// One action applied atomically in one cycle; result_valid
			// tells the key generator the next lookup may start
			if (busy_q)
			begin
				result_valid <= 1'b1;
				if (act0_q[9:8] != 2'h0)
				begin
					stage_action <= act0_q[9:8];
					if (ctrl_q[`CNLC_CTRL_REDUCED])
						forced_stage_point <= pt_small[4:0];
					else if (act0_q[4:0] <= `CNLC_PT_MAX)
						forced_stage_point <= act0_q[4:0];
				end
				else
					stage_action <= 2'h0;
				lookups_finished <= act0_q[13:10] == `CNLC_KEY_DONE;
				key_swap_dst <=
					act0_q[13:10] == `CNLC_KEY_NORMAL_DST;
				key_format <= next_key(act0_q[13:10]);
				frame_ptr <= new_ptr;
				// Write-back lets a chained action start at the new spot
				frame_q[7:0] <= new_ptr;
				if (type_moves(frame_q[7:0], new_ptr, frame_q[9:8],
					act0_q[13:10]))
				begin
					frame_type <= act0_q[24:23];
					frame_q[9:8] <= act0_q[24:23];
				end
				else
					frame_type <= frame_q[9:8];
				// Strip uses the updated pointer, clipped at the limit
				strip_req <= act0_q[25];
				strip_len <= strip_amount(act0_q[25], new_ptr);
				// Clip flag lets software see a strip that fell short
				strip_clip_q <= act0_q[25] & (new_ptr > `CNLC_STRIP_MAX);
			end
		end
	end
endmodule // cnlc_action_ctrl

/* tb/cnlc_action_ctrl_assertions.sv */
// Port checker for the action controller.
// Assumes binding onto cnlc_action_ctrl.
`timescale 1ns/1ps
module cnlc_chk
(
	input wire ref_clk,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire [7:0] frame_ptr,
	input wire [4:0] forced_stage_point,
	input wire [3:0] key_format,
	input wire key_swap_dst,
	input wire lookups_finished,
	input wire [7:0] strip_len,
	input wire strip_req,
	input wire result_valid
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
sequence s_go;
	psel && penable && pready && pwrite && paddr == 12'h000 && pwdata[0];
endsequence
a_go_result: assert property (s_go |-> ##[1:3] result_valid)
	else $error("no result after go");
a_ready_setup: assert property (psel && !penable |=> pready)
	else $error("pready late");
a_err_ready: assert property (pslverr |-> pready)
	else $error("pslverr without pready");
a_finish_key: assert property (result_valid |->
	lookups_finished == (key_format == 4'hf)) else $error("finish flag");
a_swap_key: assert property (result_valid |->
	key_swap_dst == (key_format == 4'h8)) else $error("swap flag");
a_strip_max: assert property (strip_len <= 8'h2a)
	else $error("strip too long");
a_strip_ptr: assert property (result_valid && strip_req |->
	strip_len == (frame_ptr > 8'h2a ? 8'h2a : frame_ptr))
	else $error("strip not at pointer");
a_point_max: assert property (forced_stage_point <= 5'h10)
	else $error("point code");
endmodule // cnlc_chk
bind cnlc_action_ctrl cnlc_chk cnlc_chk_i (.*);

/* tb/cnlc_far_model.sv */
// Rewriter stand-in; totals strip lengths.
// Assumes it sees the result outputs.
`timescale 1ns/1ps
module cnlc_far_model
(
	input wire ref_clk,
	input wire rst_n,
	input wire result_valid,
	input wire strip_req,
	input wire [7:0] strip_len,
	output reg [7:0] stripped_q
);
// Strips only on the result pulse, after the pointer moved
always @(posedge ref_clk or negedge rst_n)
	if (!rst_n)
		stripped_q <= 8'h00;
	else if (result_valid && strip_req)
		stripped_q <= stripped_q + strip_len;
endmodule // cnlc_far_model

/* tb/cnlc_tb.sv */
// Self-checking bench for the action controller.
// Assumes the map header; the far model totals strips.
`timescale 1ns/1ps
`include "cnlc_map.vh"
module testbench;
logic ref_clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0;
logic pwrite = 1'h0, pready, pslverr, key_swap_dst, lookups_finished;
logic strip_req, result_valid, sk, re;
logic [11:0] paddr = 12'h000;
logic [31:0] pwdata = 32'h0, prdata, rd, x = 32'hae4162ae;
logic [7:0] frame_ptr, strip_len, stripped_q, e, p0, sl, xs = 8'h00;
logic [1:0] frame_type, stage_action, ft, sg, kp;
logic [4:0] forced_stage_point, pt;
logic [3:0] key_format, ihl;
logic [23:0] sp;
logic [31:0] q[$];
int error_cnt = 0, n_tests = 0, i;
cnlc_action_ctrl cnlc_action_ctrl_i (.*);
cnlc_far_model cnlc_far_model_i (.*);
always #2 ref_clk = ~ref_clk;
function logic [31:0] xs32(input logic [31:0] v);
	logic [31:0] t;
	t = v ^ (v << 13);
	t = t ^ (t >> 17);
	xs32 = t ^ (t << 5);
endfunction
task chk(input string n, input logic [31:0] ex, input logic [31:0] s);
	n_tests++;
	if (s !== ex)
	begin
		error_cnt++;
		$display("[ERR] %s exp %h got %h", n, ex, s);
	end
endtask
task test_done;
	$display("checks %0d mismatches %0d", n_tests, error_cnt);
	if (error_cnt == 0 && n_tests > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
// Request held until pready is seen at an edge
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	@(posedge ref_clk);
	psel <= 1'h1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge ref_clk);
	penable <= 1'h1;
	do @(posedge ref_clk); while (pready !== 1'h1);
	rd = prdata;
	re = pslverr;
	psel <= 1'h0;
	penable <= 1'h0;
endtask
always @(posedge ref_clk)
	if (result_valid)
		chk("result", q.pop_front(), {lookups_finished, key_swap_dst,
			frame_ptr, frame_type, forced_stage_point, stage_action,
			key_format, strip_req, strip_len});
initial
begin
	repeat (4000) @(posedge ref_clk);
	error_cnt++;
	test_done;
end
initial
begin
	repeat (2) @(posedge ref_clk);
	rst_n <= 1'h1;
	for (i = 0; i < 60; i++)
	begin
		x = xs32(x);
		p0 = {4'h0, x[3:0]};
		ft = x[6] ? 2'h3 : 2'h0;
		ihl = 4'h5 + {1'h0, x[9:7]};
		kp = x[11:10];
		pt = x[31:27] > 5'h10 ? 5'h10 : x[31:27];
		sp = `CNLC_PTBL_RESET >> (3 * x[2:0]);
		if (i[0])
			pt = {2'h0, sp[2:0]};
		sg = x[26:25] == 2'h0 ? 2'h1 : x[26:25];
		e = p0 + ((kp == 2'h1 || kp == 2'h2) && ft == 2'h0 ? 8'h0e + 4 * x[5:4]
			+ (kp == 2'h2 ? 4 * ihl : 8'h00) : 8'h00);
		e = e + 4 * x[17:16] + 2 * x[22:18];
		sk = e != p0 || (ft == 2'h3 && x[15:12] != 4'h0);
		sl = x[24] ? (e > 8'h2a ? 8'h2a : e) : 8'h00;
		xs = xs + sl;
		apb(1'h1, `CNLC_ADDR_FRAME, {14'h0, ihl, 2'h1, x[5:4], ft, p0});
		apb(1'h1, `CNLC_ADDR_ACT0, {6'h0, x[24], x[24:23], kp, x[22:12],
			sg, x[2:0], pt});
		q.push_back({x[15:12] == 4'hf, x[15:12] == 4'h8, e,
			sk ? x[24:23] : ft, pt, sg, x[15:12], x[24], sl});
		apb(1'h1, `CNLC_ADDR_CTRL, {30'h0, i[0], 1'h1});
		repeat (4) @(posedge ref_clk);
	end
	$display("random actions done");
	apb(1'h0, 12'h0fc, 32'h0);
	chk("unmapped", 32'h1, {rd[30:0], re});
	chk("stripped", {24'h0, xs}, {24'h0, stripped_q});
	$display("unmapped and strip total done");
	test_done;
end
endmodule // testbench
